/* File: design/bdc_defs.svh */
`ifndef BDC_DEFS_SVH
`define BDC_DEFS_SVH

// two-wire bus address byte, r/w bit excluded from the compare
`define BDC_ADDR_BYTE       8'h44
`define BDC_BITS_PER_BYTE   4'h8

// register offsets (command byte values)
`define BDC_OFF_CFG0        8'h0c
`define BDC_OFF_CFG1        8'h0d
`define BDC_OFF_CFG2        8'h0e

// reset values, and the value read back from unmapped offsets
`define BDC_RST_CFG0        8'h0b
`define BDC_RST_CFG1        8'h00
`define BDC_RST_CFG2        8'hfc
`define BDC_READ_NONE       8'h00

// writable bits; reserved bits keep their reset value
`define BDC_WMASK_CFG0      8'hf7
`define BDC_WMASK_CFG1      8'hff
`define BDC_WMASK_CFG2      8'h03

// clock_and_reset_line_direction fields
`define BDC_B_OSC_A         7
`define BDC_B_OSC_B         6
`define BDC_B_SPDIF_MSEL    5
`define BDC_B_SPDIF_SRC     4
`define BDC_B_CFG0_RSVD     3
`define BDC_B_SPDIF_BUF     2
`define BDC_B_TGT_B         1
`define BDC_B_TGT_A         0

// audio_port_line_direction fields
`define BDC_B_FMT2          7
`define BDC_B_FMT1          6
`define BDC_B_ROLE2         5
`define BDC_B_ROLE1         4
`define BDC_B_HDR_B         3
`define BDC_B_HDR_A         2
`define BDC_B_BRD_B         1
`define BDC_B_BRD_A         0

// mclk_output_enable_direction fields
`define BDC_B_PKG_B         1
`define BDC_B_PKG_A         0
`define BDC_CFG2_RSVD_HI    7
`define BDC_CFG2_RSVD_LO    2

`endif

/* File: design/bdc_pkg.sv */
package bdc_pkg;

  typedef enum logic [3:0] {
    BDC_IDLE,
    BDC_ADDR,
    BDC_ADDR_ACK,
    BDC_CMD,
    BDC_CMD_ACK,
    BDC_WDATA,
    BDC_WDATA_ACK,
    BDC_RDATA,
    BDC_RDATA_ACK
  } bdc_state_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
  } bdc_sync_t;

  typedef struct packed {
    bdc_state_t  state;
    logic [3:0]  cnt;
    logic [7:0]  shift;
    logic        rw;
    logic [7:0]  ptr;
    logic [7:0]  tx;
    logic        sda_low;
    logic [7:0]  cfg0;
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
  } bdc_regs_t;

endpackage : bdc_pkg

/* File: design/bdc_pins_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface bdc_pins_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport src (output scl_rise, scl_fall, start, stop, sda);
  modport snk (input  scl_rise, scl_fall, start, stop, sda);
endinterface : bdc_pins_if

`default_nettype wire

/* File: design/bdc_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module bdc_pin_sync (
  input  wire logic i_clock, // 25 MHz
  input  wire logic i_rst_n, // async, active low
  input  wire logic i_scl,   // bus clock pin
  input  wire logic i_sda,   // bus data pin level
  bdc_pins_if.src   pins     // synced levels and events
);
  import bdc_pkg::*;

  bdc_sync_t r;
  bdc_sync_t r_nxt;

  // idle bus is high, so the chain resets high to avoid a false start
  always_comb begin
    r_nxt       = r;
    r_nxt.scl_m = i_scl;
    r_nxt.scl_s = r.scl_m;
    r_nxt.scl_d = r.scl_s;
    r_nxt.sda_m = i_sda;
    r_nxt.sda_s = r.sda_m;
    r_nxt.sda_d = r.sda_s;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '1;
    end else begin
      r <= r_nxt;
    end
  end

  // only the second and third stages are looked at
  assign pins.scl_rise = r.scl_s & ~r.scl_d;
  assign pins.scl_fall = ~r.scl_s & r.scl_d;
  assign pins.start    = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
  assign pins.stop     = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
  assign pins.sda      = r.sda_s;

endmodule : bdc_pin_sync

`default_nettype wire

/* File: design/bdc_io_dir_cfg.sv */
// Functional notes
// [RL1] 0x0C bit7: oscillator A enable line direction
// [RL2] 0x0C bit6: oscillator B enable line direction
// [RL3] 0x0C bit5: S/PDIF clock master select direction
// [RL4] 0x0C bit4: S/PDIF clock source device direction
// [RL5] 0x0C bit2: S/PDIF buffer reset direction
// [RL6] 0x0D bit7: second port format direction
// [RL7] 0x0D bit6: first port format direction
// [RL8] 0x0D bit5: second port role direction
// [RL9] 0x0D bit4: first port role direction
// [RL10] 0x0D bit3: header B clock role direction
// [RL11] 0x0D bit2: header A clock role direction
// [RL12] 0x0D bit1: board clock B enable direction
// [RL13] 0x0D bit0: board clock A enable direction
// [RL14] 0x0E bit1: package B clock OE direction
// [RL15] 0x0E bit0: package A clock OE direction
// [RL16] 0x0C bits1/0: target resets, default one
// [RL17] host addresses expander at 0x44
`timescale 1ns/100ps
`include "bdc_defs.svh"
`default_nettype none

module bdc_io_dir_cfg (
  input  wire logic i_clock,                    // 25 MHz
  input  wire logic i_rst_n,                    // async, active low
  input  wire logic i_scl,                      // bus clock pin
  input  wire logic i_sda,                      // bus data pin level
  output logic      o_sda,                      // data drive value
  output logic      o_sda_oe,                   // data pulled low
  output logic      o_osc_a_enable_dir,         // 0 out, 1 in
  output logic      o_osc_b_enable_dir,         // 0 out, 1 in
  output logic      o_spdif_clock_master_sel_dir, // 0 out, 1 in
  output logic      o_spdif_clock_source_dev_dir, // 0 out, 1 in
  output logic      o_spdif_buf_reset_dir,      // 0 out, 1 in
  output logic      o_target_b_reset,           // 1 enabled
  output logic      o_target_a_reset,           // 1 enabled
  output logic      o_second_port_fmt_sel_dir,  // 0 out, 1 in
  output logic      o_first_port_fmt_sel_dir,   // 0 out, 1 in
  output logic      o_second_port_role_dir,     // 0 out, 1 in
  output logic      o_first_port_role_dir,      // 0 out, 1 in
  output logic      o_header_b_clock_role_dir,  // 0 out, 1 in
  output logic      o_header_a_clock_role_dir,  // 0 out, 1 in
  output logic      o_board_clock_b_enable_dir, // 0 out, 1 in
  output logic      o_board_clock_a_enable_dir, // 0 out, 1 in
  output logic      o_pkg_b_clock_oe_dir,       // 0 out, 1 in
  output logic      o_pkg_a_clock_oe_dir        // 0 out, 1 in
);
  import bdc_pkg::*;

  bdc_pins_if pins ();

  bdc_pin_sync u_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_scl   (i_scl),
    .i_sda   (i_sda),
    .pins    (pins)
  );

  bdc_regs_t  r;
  bdc_regs_t  r_nxt;
  logic       wr_en;
  logic [7:0] rd_data;
  logic       addr_hit;

  // the r/w bit is excluded so 0x44 and 0x45 both select this device
  assign addr_hit = ({r.shift[7:1], 1'b0} == `BDC_ADDR_BYTE); // RL17

  always_comb begin
    case (r.ptr)
      `BDC_OFF_CFG0: rd_data = r.cfg0;
      `BDC_OFF_CFG1: rd_data = r.cfg1;
      `BDC_OFF_CFG2: rd_data = r.cfg2;
      default:       rd_data = `BDC_READ_NONE;
    endcase
  end

  // start and stop come first so an abort in mid-byte always wins
  always_comb begin
    r_nxt = r;
    wr_en = 1'b0;
    if (pins.stop) begin
      r_nxt.state   = BDC_IDLE;
      r_nxt.sda_low = 1'b0;
    end else if (pins.start) begin
      // repeated start keeps the pointer for a combined read
      r_nxt.state   = BDC_ADDR;
      r_nxt.cnt     = '0;
      r_nxt.sda_low = 1'b0;
    end else begin
      case (r.state)
        BDC_IDLE: begin
          r_nxt.cnt = '0;
        end
        BDC_ADDR, BDC_CMD, BDC_WDATA: begin
          if (pins.scl_rise) begin
            r_nxt.shift = {r.shift[6:0], pins.sda};
            r_nxt.cnt   = r.cnt + 4'h1;
          end else if (pins.scl_fall && r.cnt == `BDC_BITS_PER_BYTE) begin
            r_nxt.cnt = '0;
            if (r.state == BDC_ADDR) begin
              if (addr_hit) begin
                r_nxt.rw      = r.shift[0];
                r_nxt.sda_low = 1'b1; // RL17
                r_nxt.state   = BDC_ADDR_ACK;
              end else begin
                r_nxt.state = BDC_IDLE;
              end
            end else if (r.state == BDC_CMD) begin
              r_nxt.ptr     = r.shift;
              r_nxt.sda_low = 1'b1;
              r_nxt.state   = BDC_CMD_ACK;
            end else begin
              wr_en         = 1'b1;
              r_nxt.ptr     = r.ptr + 8'h01;
              r_nxt.sda_low = 1'b1;
              r_nxt.state   = BDC_WDATA_ACK;
            end
          end
        end
        BDC_ADDR_ACK: begin
          if (pins.scl_fall) begin
            if (r.rw) begin
              r_nxt.tx      = rd_data;
              r_nxt.sda_low = ~rd_data[7];
              r_nxt.state   = BDC_RDATA;
            end else begin
              r_nxt.sda_low = 1'b0;
              r_nxt.state   = BDC_CMD;
            end
          end
        end
        BDC_CMD_ACK, BDC_WDATA_ACK: begin
          if (pins.scl_fall) begin
            r_nxt.sda_low = 1'b0;
            r_nxt.state   = BDC_WDATA;
          end
        end
        // read bits change a clock after the detected fall, inside the low
        BDC_RDATA: begin
          if (pins.scl_rise) begin
            r_nxt.cnt = r.cnt + 4'h1;
          end else if (pins.scl_fall) begin
            if (r.cnt == `BDC_BITS_PER_BYTE) begin
              r_nxt.cnt     = '0;
              r_nxt.sda_low = 1'b0;
              r_nxt.state   = BDC_RDATA_ACK;
            end else begin
              r_nxt.tx      = {r.tx[6:0], 1'b0};
              r_nxt.sda_low = ~r.tx[6];
            end
          end
        end
        BDC_RDATA_ACK: begin
          // a not-acknowledge ends the read; the next byte is fetched early
          if (pins.scl_rise) begin
            if (pins.sda) begin
              r_nxt.state = BDC_IDLE;
            end else begin
              r_nxt.ptr = r.ptr + 8'h01;
            end
          end else if (pins.scl_fall) begin
            r_nxt.tx      = rd_data;
            r_nxt.sda_low = ~rd_data[7];
            r_nxt.state   = BDC_RDATA;
          end
        end
        default: begin
          r_nxt.state   = BDC_IDLE;
          r_nxt.sda_low = 1'b0;
        end
      endcase
    end

    // reserved bits are not writable and keep reading their reset value
    if (wr_en) begin
      case (r.ptr)
        `BDC_OFF_CFG0: begin
          r_nxt.cfg0 = (r.shift & `BDC_WMASK_CFG0) |
                       (`BDC_RST_CFG0 & ~`BDC_WMASK_CFG0); // RL1 RL5 RL16
        end
        `BDC_OFF_CFG1: begin
          r_nxt.cfg1 = (r.shift & `BDC_WMASK_CFG1) |
                       (`BDC_RST_CFG1 & ~`BDC_WMASK_CFG1); // RL6 RL13
        end
        `BDC_OFF_CFG2: begin
          r_nxt.cfg2 = (r.shift & `BDC_WMASK_CFG2) |
                       (`BDC_RST_CFG2 & ~`BDC_WMASK_CFG2); // RL14 RL15
        end
        default: begin
          r_nxt.cfg0 = r.cfg0;
        end
      endcase
    end
  end

  // reset loads the defaults; the bus engine starts idle and released
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r         <= '0;
      r.state   <= BDC_IDLE;
      r.cfg0    <= `BDC_RST_CFG0; // RL16
      r.cfg1    <= `BDC_RST_CFG1; // RL6
      r.cfg2    <= `BDC_RST_CFG2;
    end else begin
      r <= r_nxt;
    end
  end

  // open drain: only ever pulls low
  assign o_sda    = 1'b0;
  assign o_sda_oe = r.sda_low;

  assign o_osc_a_enable_dir           = r.cfg0[`BDC_B_OSC_A];      // RL1
  assign o_osc_b_enable_dir           = r.cfg0[`BDC_B_OSC_B];      // RL2
  assign o_spdif_clock_master_sel_dir = r.cfg0[`BDC_B_SPDIF_MSEL]; // RL3
  assign o_spdif_clock_source_dev_dir = r.cfg0[`BDC_B_SPDIF_SRC];  // RL4
  assign o_spdif_buf_reset_dir        = r.cfg0[`BDC_B_SPDIF_BUF];  // RL5
  assign o_target_b_reset             = r.cfg0[`BDC_B_TGT_B];      // RL16
  assign o_target_a_reset             = r.cfg0[`BDC_B_TGT_A];      // RL16
  assign o_second_port_fmt_sel_dir    = r.cfg1[`BDC_B_FMT2];       // RL6
  assign o_first_port_fmt_sel_dir     = r.cfg1[`BDC_B_FMT1];       // RL7
  assign o_second_port_role_dir       = r.cfg1[`BDC_B_ROLE2];      // RL8
  assign o_first_port_role_dir        = r.cfg1[`BDC_B_ROLE1];      // RL9
  assign o_header_b_clock_role_dir    = r.cfg1[`BDC_B_HDR_B];      // RL10
  assign o_header_a_clock_role_dir    = r.cfg1[`BDC_B_HDR_A];      // RL11
  assign o_board_clock_b_enable_dir   = r.cfg1[`BDC_B_BRD_B];      // RL12
  assign o_board_clock_a_enable_dir   = r.cfg1[`BDC_B_BRD_A];      // RL13
  assign o_pkg_b_clock_oe_dir         = r.cfg2[`BDC_B_PKG_B];      // RL14
  assign o_pkg_a_clock_oe_dir         = r.cfg2[`BDC_B_PKG_A];      // RL15

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr_at(logic [7:0] off);
    wr_en && (r.ptr == off);
  endsequence

  sequence s_addr_done;
    (r.state == BDC_ADDR) && pins.scl_fall && !pins.start && !pins.stop &&
    (r.cnt == `BDC_BITS_PER_BYTE);
  endsequence

  sequence s_byte_load;
    !pins.start && !pins.stop && pins.scl_fall &&
    ((r.state == BDC_ADDR_ACK && r.rw) || r.state == BDC_RDATA_ACK);
  endsequence

  AST_CFG0_OSC: assert property ( // RL1 RL2
    s_wr_at(`BDC_OFF_CFG0) |=>
      o_osc_a_enable_dir == $past(r.shift[`BDC_B_OSC_A]) &&
      o_osc_b_enable_dir == $past(r.shift[`BDC_B_OSC_B]))
    else $error("osc direction not taken from written byte");

  AST_CFG0_SPDIF: assert property ( // RL3 RL4 RL5
    s_wr_at(`BDC_OFF_CFG0) |=>
      o_spdif_clock_master_sel_dir == $past(r.shift[`BDC_B_SPDIF_MSEL]) &&
      o_spdif_clock_source_dev_dir == $past(r.shift[`BDC_B_SPDIF_SRC]) &&
      o_spdif_buf_reset_dir == $past(r.shift[`BDC_B_SPDIF_BUF]) &&
      r.cfg0[`BDC_B_CFG0_RSVD])
    else $error("spdif direction or reserved bit wrong after write");

  AST_CFG0_TARGETS: assert property ( // RL16
    s_wr_at(`BDC_OFF_CFG0) |=>
      o_target_a_reset == $past(r.shift[`BDC_B_TGT_A]) &&
      o_target_b_reset == $past(r.shift[`BDC_B_TGT_B]))
    else $error("target reset bits not taken from written byte");

  AST_CFG1_PORTS: assert property ( // RL6 RL7 RL8 RL9
    s_wr_at(`BDC_OFF_CFG1) |=>
      {o_second_port_fmt_sel_dir, o_first_port_fmt_sel_dir,
       o_second_port_role_dir, o_first_port_role_dir} ==
      $past(r.shift[`BDC_B_FMT2:`BDC_B_ROLE1]))
    else $error("port direction bits not taken from written byte");

  AST_CFG1_CLOCKS: assert property ( // RL10 RL11 RL12 RL13
    s_wr_at(`BDC_OFF_CFG1) |=>
      {o_header_b_clock_role_dir, o_header_a_clock_role_dir,
       o_board_clock_b_enable_dir, o_board_clock_a_enable_dir} ==
      $past(r.shift[`BDC_B_HDR_B:`BDC_B_BRD_A]))
    else $error("clock direction bits not taken from written byte");

  AST_CFG2_OE: assert property ( // RL14 RL15
    s_wr_at(`BDC_OFF_CFG2) |=>
      o_pkg_b_clock_oe_dir == $past(r.shift[`BDC_B_PKG_B]) &&
      o_pkg_a_clock_oe_dir == $past(r.shift[`BDC_B_PKG_A]) &&
      (&r.cfg2[`BDC_CFG2_RSVD_HI:`BDC_CFG2_RSVD_LO]))
    else $error("package oe direction wrong after write");

  AST_HOLD: assert property ( // RL1 RL6 RL14
    !wr_en |=> $stable(r.cfg0) && $stable(r.cfg1) && $stable(r.cfg2))
    else $error("configuration changed without a write");

  AST_RESET_VALUES: assert property ( // RL16 RL6
    !$past(i_rst_n) |->
      r.cfg0 == `BDC_RST_CFG0 && r.cfg1 == `BDC_RST_CFG1 &&
      r.cfg2 == `BDC_RST_CFG2 && !o_sda_oe)
    else $error("configuration not at reset value after reset");

  AST_ADDR_ACK: assert property ( // RL17
    s_addr_done ##0 ({r.shift[7:1], 1'b0} == `BDC_ADDR_BYTE)
      |=> o_sda_oe && r.state == BDC_ADDR_ACK)
    else $error("own address not acknowledged");

  AST_ADDR_MISS: assert property ( // RL17
    s_addr_done ##0 ({r.shift[7:1], 1'b0} != `BDC_ADDR_BYTE)
      |=> !o_sda_oe [*2])
    else $error("foreign address acknowledged");

  AST_RSVD_FIXED: assert property ( // RL5 RL14
    r.cfg0[`BDC_B_CFG0_RSVD] &&
    (&r.cfg2[`BDC_CFG2_RSVD_HI:`BDC_CFG2_RSVD_LO]))
    else $error("reserved bit lost its fixed value");

  AST_STOP_IDLE: assert property ( // RL17
    pins.stop |=> r.state == BDC_IDLE && !o_sda_oe)
    else $error("stop did not return the bus port to idle");

  AST_START_ADDR: assert property ( // RL17
    pins.start |=> r.state == BDC_ADDR && r.cnt == '0 && !o_sda_oe)
    else $error("start did not restart address reception");

  // an ack let go early reads as a not-acknowledge at the host
  AST_ACK_STANDS: assert property ( // RL17
    r.state inside {BDC_ADDR_ACK, BDC_CMD_ACK, BDC_WDATA_ACK} |-> o_sda_oe)
    else $error("acknowledge released early");

  AST_READ_RELEASE: assert property ( // RL17
    r.state == BDC_RDATA_ACK |-> !o_sda_oe)
    else $error("line still pulled while the host answers a read");

  // offsets past the bank read as zero, so the line is pulled low for every data bit
  AST_READ_LOAD: assert property ( // RL1 RL6 RL14 RL16
    s_byte_load |=>
      r.tx == ($past(r.ptr) == `BDC_OFF_CFG0 ? r.cfg0 :
               $past(r.ptr) == `BDC_OFF_CFG1 ? r.cfg1 :
               $past(r.ptr) == `BDC_OFF_CFG2 ? r.cfg2 : `BDC_READ_NONE))
    else $error("read byte not loaded from the addressed register");

  AST_PTR_STEP: assert property ( // RL17
    wr_en |=> r.ptr == $past(r.ptr) + 8'h01)
    else $error("pointer did not advance after a data byte");

endmodule : bdc_io_dir_cfg

`default_nettype wire

/* File: verif/bdc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module bdc_host_model (
  input  wire logic i_clock,  // bench clock
  input  wire logic i_dev_oe, // device pulls data low
  output logic      o_scl,    // bus clock, host owned
  output logic      o_sda     // resolved data wire
);
  logic host_low_r;

  // open drain with pull-up: a released wire reads high, never stale
  assign o_sda = ~(host_low_r | i_dev_oe);

  initial begin
    o_scl      = 1'b1;
    host_low_r = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick

  // 8-clock phases, twice the shortest phase the device can see
  task automatic bus_bit(input logic b, output logic seen);
    o_scl <= 1'b0;
    tick(4);
    host_low_r <= ~b;
    tick(4);
    o_scl <= 1'b1;
    tick(4);
    seen = o_sda;
    tick(4);
  endtask : bus_bit

  // data moves while the clock is high: start falls, stop rises
  task automatic bus_cond(input logic is_start);
    o_scl <= 1'b0;
    tick(4);
    host_low_r <= ~is_start;
    tick(4);
    o_scl <= 1'b1;
    tick(8);
    host_low_r <= is_start;
    tick(8);
  endtask : bus_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(b[i], seen);
    end
    bus_bit(1'b1, seen);
    ack = ~seen;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(1'b1, b[i]);
    end
    bus_bit(last, seen);
  endtask : recv_byte
endmodule : bdc_host_model

`default_nettype wire

/* File: verif/bdc_io_dir_cfg_tb_top.sv */
`timescale 1ns/100ps
`include "bdc_defs.svh"
`default_nettype none

module bdc_io_dir_cfg_tb_top;
  localparam int WMASK [3] = '{`BDC_WMASK_CFG0, `BDC_WMASK_CFG1,
                               `BDC_WMASK_CFG2};
  logic            i_clock = 1'b0;
  logic            i_rst_n;
  logic            scl;
  logic            sda;
  logic            dev_oe;
  logic            dev_sda;
  wire logic [7:0] out0;
  wire logic [7:0] out1;
  wire logic [7:0] out2;
  int              regs_m [3];
  int              seed;
  int              mismatches;
  int              check_count;

  // reserved places have no pin; they always read as one
  assign out0[3]   = 1'b1;
  assign out2[7:2] = 6'h3f;

  always #20 i_clock = ~i_clock;

  bdc_io_dir_cfg bdc_io_dir_cfg_inst (
    .i_clock                      (i_clock),
    .i_rst_n                      (i_rst_n),
    .i_scl                        (scl),
    .i_sda                        (sda),
    .o_sda                        (dev_sda),
    .o_sda_oe                     (dev_oe),
    .o_osc_a_enable_dir           (out0[7]),
    .o_osc_b_enable_dir           (out0[6]),
    .o_spdif_clock_master_sel_dir (out0[5]),
    .o_spdif_clock_source_dev_dir (out0[4]),
    .o_spdif_buf_reset_dir        (out0[2]),
    .o_target_b_reset             (out0[1]),
    .o_target_a_reset             (out0[0]),
    .o_second_port_fmt_sel_dir    (out1[7]),
    .o_first_port_fmt_sel_dir     (out1[6]),
    .o_second_port_role_dir       (out1[5]),
    .o_first_port_role_dir        (out1[4]),
    .o_header_b_clock_role_dir    (out1[3]),
    .o_header_a_clock_role_dir    (out1[2]),
    .o_board_clock_b_enable_dir   (out1[1]),
    .o_board_clock_a_enable_dir   (out1[0]),
    .o_pkg_b_clock_oe_dir         (out2[1]),
    .o_pkg_a_clock_oe_dir         (out2[0])
  );

  bdc_host_model bdc_host_model_inst (
    .i_clock  (i_clock),
    .i_dev_oe (dev_oe),
    .o_scl    (scl),
    .o_sda    (sda)
  );

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic model_reset();
    regs_m = '{`BDC_RST_CFG0, `BDC_RST_CFG1, `BDC_RST_CFG2};
  endtask : model_reset

  task automatic check_outs();
    check("cfg0 lines", out0, 8'(regs_m[0]));
    check("cfg1 lines", out1, 8'(regs_m[1]));
    check("cfg1 clock lines", out1, 8'(regs_m[1]));
    check("cfg2 lines", out2, 8'(regs_m[2]));
    check("sda drive", {7'h0, dev_sda}, 8'h00);
  endtask : check_outs

  // random data burst from a start offset; pointer steps per byte
  // a foreign address still gets its bytes, which must all go unanswered
  task automatic wr(input int off, input int n, input logic [7:0] addr);
    logic       ack;
    logic       hit;
    logic [7:0] d;
    int         k;
    hit = ({addr[7:1], 1'b0} == `BDC_ADDR_BYTE);
    bdc_host_model_inst.bus_cond(1'b1);
    bdc_host_model_inst.send_byte(addr, ack);
    check("address ack", {7'h0, ack}, {7'h0, hit});
    bdc_host_model_inst.send_byte(8'(off), ack);
    check("offset ack", {7'h0, ack}, {7'h0, hit});
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      bdc_host_model_inst.send_byte(d, ack);
      check("data ack", {7'h0, ack}, {7'h0, hit});
      k = off + i - 'h0c;
      if (hit && k >= 0 && k < 3) begin
        regs_m[k] = (regs_m[k] & ~WMASK[k]) | (int'(d) & WMASK[k]);
      end
    end
    bdc_host_model_inst.bus_cond(1'b0);
    repeat (4) @(posedge i_clock);
    check_outs();
  endtask : wr

  task automatic rd(input int off, input int n);
    logic       ack;
    logic [7:0] d;
    int         k;
    bdc_host_model_inst.bus_cond(1'b1);
    bdc_host_model_inst.send_byte(8'h44, ack);
    bdc_host_model_inst.send_byte(8'(off), ack);
    bdc_host_model_inst.bus_cond(1'b1);
    bdc_host_model_inst.send_byte(8'h45, ack);
    check("read address ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      bdc_host_model_inst.recv_byte(i == n - 1, d);
      k = off + i - 'h0c;
      check("read data", d,
            (k >= 0 && k < 3) ? 8'(regs_m[k]) : `BDC_READ_NONE);
    end
    bdc_host_model_inst.bus_cond(1'b0);
  endtask : rd

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    i_rst_n     = 1'b0;
    seed        = 87285;
    mismatches  = 0;
    check_count = 0;
    model_reset();
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    check_outs();
    rd('h0c, 3);
    $display("test reset values done");
    for (int r = 0; r < 5; r++) begin
      wr('h0c, 3, 8'h44);
      rd('h0c, 3);
    end
    $display("test burst write and read back done");
    // burst runs off the end of the bank: extra byte dropped, reads zero
    wr('h0d, 3, 8'h44);
    rd('h0d, 3);
    $display("test unmapped offset done");
    // foreign address must be ignored whole
    wr('h0c, 2, 8'h46);
    rd('h0c, 3);
    $display("test foreign address done");
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    model_reset();
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    check_outs();
    $display("test mid-run reset done");
    print_verdict();
  end

  // a full run takes well under a third of this span
  initial begin
    #(40 * 60000);
    mismatches++;
    $display("BAD watchdog expected done seen timeout");
    print_verdict();
  end
endmodule : bdc_io_dir_cfg_tb_top

`default_nettype wire
